// File: cpu_ctl_top.sv
// cpu_ctl_top: cpu operating mode control, error classification and interrupt arbitration
// assumes: clock_in 10 MHz, synchronous active high reset, all inputs synchronous
// Behaviour
// R1 - triggers arriving before a source is enabled are discarded
// R2 - routines not matching interrupt parameters raise an error and halt
// R3 - simultaneous triggers are serviced in configured priority order
// R4 - a higher priority trigger preempts a running lower priority routine; the code preempts only while no routine is stacked
// R5 - periodic sources fire repeatedly at their period in 10 ms units
// R6 - eight periodic sources on standard parts, four on economy parts
// R7 - standard edge sources fire on rising, falling or both edges
// R8 - economy has four edge sources, rising edge only
// R9 - counter sources fire on a compare match, four channels
// R10 - standard parts allow at most eight configured sources in total
// R11 - beyond two pending triggers of a busy source are ignored
// R12 - errors are fatal (force stop) or ordinary (warning flag only)
// R13 - hardware configuration mismatch forces stop
// R14 - numeric error only flags; overrun or i/o failure forces stop
// R15 - every error is recorded in one system error flag location
// R16 - run entry initialises data and validates program; run executes and refreshes
// R17 - stop entry clears output image and refreshes outputs; no execution
// R18 - pause holds data and input image; run resumes from there; the code keeps io_refresh_out high in pause
// R19 - debug only from stop; entry initialises data, clears outputs, refreshes inputs
// R20 - debug halts after a step, breakpoint, device condition or scan count
// R21 - a program stop instruction can also change the mode
// R22 - selector switch positions map to local or remote modes as tabled
`timescale 1ns/1ps
module cpu_ctl_top
  import cpu_ctl_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic economy_in,
  input wire src_cfg_type [num_sources-1:0] src_cfg_in,
  input wire logic [num_sources-1:0] routine_present_in,
  input wire logic [num_sources-1:0] interrupt_enable_instruction_in,
  input wire logic [num_sources-1:0] input_edge_interrupt_in,
  input wire logic [num_counter_ch-1:0] counter_match_interrupt_in,
  input wire logic routine_return_in,
  input wire error_in_type error_in,
  input wire logic [7:0] error_code_in,
  input wire switch_pos_type switch_in,
  input wire logic remote_run_req_in,
  input wire logic remote_pause_req_in,
  input wire logic remote_stop_req_in,
  input wire logic remote_debug_req_in,
  input wire logic stop_instruction_in,
  input wire logic scan_end_in,
  input wire debug_cond_type debug_cond_in,
  input wire logic instr_done_in,
  input wire logic breakpoint_hit_in,
  input wire logic device_cond_in,
  input wire logic [15:0] debug_scans_in,
  input wire logic debug_go_in,
  output mode_type mode_out,
  output logic remote_out,
  output logic execute_out,
  output logic io_refresh_out,
  output logic init_data_out,
  output logic clear_outputs_out,
  output logic input_refresh_out,
  output logic validate_out,
  output logic debug_halted_out,
  output logic [3:0] service_id_out,
  output logic preempt_out,
  output logic config_error_out,
  output logic warning_out,
  output logic [7:0] system_error_flag_out
);
  mode_type mode;
  mode_type next_mode;
  logic remote;
  logic next_remote;
  switch_pos_type switch_prev;
  logic [tick_width-1:0] tick_count;
  logic tick;
  logic [num_sources-1:0] pending;
  logic [num_sources-1:0] active;
  logic [num_sources-1:0] take;
  logic [num_sources-1:0] done;
  logic [num_sources-1:0] allowed;
  logic [3:0] best_id;
  logic [2:0] best_level;
  logic [3:0] current_id;
  logic [3:0] stack_id;
  logic [3:0] src_count;
  logic mismatch;
  logic fatal;
  logic ordinary;
  logic switch_moved;
  logic want_debug;
  logic [15:0] scan_count;
  logic halt_now;
  logic running;

  // count configured sources, used for the total limit
  function automatic logic [3:0] count_used(input src_cfg_type [num_sources-1:0] cfg);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < num_sources; i++) begin
      if (cfg[i].kind != src_unused) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // source index usable on this variant: economy has fewer sources
  function automatic logic slot_ok(input int idx, input logic eco);
    return eco ? (idx < max_sources_eco) : (idx < max_sources_std);
  endfunction

  // 10 ms time base shared by all periodic sources
  assign tick = (tick_count == tick_width'(tick_cycles - 1));
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick ? '0 : tick_count + 1'b1;
    end
  end

  // per source logic; triggers are accepted only in run mode
  for (genvar g = 0; g < num_sources; g++) begin : g_src
    assign allowed[g] = interrupt_enable_instruction_in[g] && slot_ok(g, economy_in) && (mode == mode_run); // [R6] [R8]
    irq_source_unit u_src (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .cfg_in(src_cfg_in[g]),
      .economy_in(economy_in),
      .tick_in(tick),
      .contact_in(input_edge_interrupt_in[g]),
      .match_in(counter_match_interrupt_in),
      .enable_in(allowed[g]),
      .take_in(take[g]),
      .done_in(done[g]),
      .pending_out(pending[g]),
      .active_out(active[g])
    );
  end

  // parameter versus routine check and source total limit
  assign src_count = count_used(src_cfg_in);
  assign mismatch = (src_count > 4'(max_sources_std)) || (economy_in && src_count > 4'(max_sources_eco)); // [R10]
  always_comb begin
    config_error_out = mismatch;
    for (int i = 0; i < num_sources; i++) begin
      if ((src_cfg_in[i].kind != src_unused) != routine_present_in[i]) begin
        config_error_out = 1'b1; // [R2]
      end
    end
  end

  // priority pick: lowest level number wins, ties to lowest index
  always_comb begin
    best_id = no_source;
    best_level = 3'h7;
    for (int i = num_sources - 1; i >= 0; i--) begin
      if (pending[i] && !active[i] && (best_id == no_source || src_cfg_in[i].priority_level <= best_level)) begin
        best_id = 4'(i); // [R3]
        best_level = src_cfg_in[i].priority_level;
      end
    end
  end

  // take when idle, or preempt a lower priority routine; one level of nesting kept
  assign preempt_out = (best_id != no_source) && (current_id != no_source) && (stack_id == no_source) &&
                       (best_level < src_cfg_in[current_id[2:0]].priority_level); // [R4]
  assign take = ((best_id != no_source) && (current_id == no_source || preempt_out)) ?
                num_sources'(1) << best_id[2:0] : '0;
  assign done = (routine_return_in && current_id != no_source) ? num_sources'(1) << current_id[2:0] : '0;

  // service stack: the preempted routine resumes after return
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      current_id <= no_source;
      stack_id <= no_source;
    end else if (take != '0) begin
      stack_id <= preempt_out ? current_id : stack_id; // [R4]
      current_id <= best_id;
    end else if (routine_return_in && current_id != no_source) begin
      current_id <= stack_id;
      stack_id <= no_source;
    end
  end
  assign service_id_out = current_id;

  // error classes: fatal ones force stop, ordinary ones only warn
  assign fatal = error_in.hw_fatal | error_in.config_mismatch | error_in.overrun | error_in.io_fail |
                 error_in.ext_fatal | config_error_out; // [R12] [R13] [R14]
  assign ordinary = error_in.numeric_error | error_in.ext_ordinary; // [R14]

  // switch movement detection, a held position does not override remote commands
  assign switch_moved = (switch_in != switch_prev);
  assign want_debug = remote && remote_debug_req_in && !economy_in;
  assign running = (mode == mode_run) || (mode == mode_debug && !debug_halted_out);

  // next mode: fatal first, then stop instruction, then switch, then remote tool
  always_comb begin
    next_mode = mode;
    next_remote = remote;
    if (fatal) begin
      next_mode = mode_stop; // [R12]
    end else if (stop_instruction_in && running) begin
      next_mode = mode_stop; // [R21]
    end else if (switch_moved) begin
      case (switch_in) // [R22]
        sw_run, sw_rem_to_run: begin
          next_mode = mode_run;
          next_remote = 1'b0;
        end
        sw_stop, sw_rem_to_stop: begin
          next_mode = mode_stop;
          next_remote = 1'b0;
        end
        sw_stop_to_rem: begin
          next_mode = mode_stop;
          next_remote = 1'b1;
        end
        sw_run_to_rem: begin
          next_mode = mode_pause;
          next_remote = 1'b0;
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end else if (remote) begin
      case (mode)
        mode_stop: begin
          if (want_debug) begin
            next_mode = mode_debug; // [R19]
          end else if (remote_run_req_in) begin
            next_mode = mode_run;
          end
        end
        mode_run: begin
          if (remote_stop_req_in) begin
            next_mode = mode_stop;
          end else if (remote_pause_req_in) begin
            next_mode = mode_pause;
          end
        end
        mode_pause: begin
          if (remote_stop_req_in) begin
            next_mode = mode_stop;
          end else if (remote_run_req_in) begin
            next_mode = mode_run; // [R18]
          end
        end
        mode_debug: begin
          if (remote_stop_req_in) begin
            next_mode = mode_stop;
          end
        end
        default: begin
          next_mode = mode_stop;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode <= mode_stop;
      remote <= 1'b0;
      switch_prev <= sw_stop;
    end else begin
      mode <= next_mode;
      remote <= next_remote;
      switch_prev <= switch_in;
    end
  end

  // entry actions pulse for one cycle on a mode change; pause to run keeps data
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      init_data_out <= 1'b0;
      validate_out <= 1'b0;
      clear_outputs_out <= 1'b0;
      input_refresh_out <= 1'b0;
    end else begin
      init_data_out <= (next_mode != mode) && ((next_mode == mode_run && mode != mode_pause) ||
                       next_mode == mode_debug); // [R16] [R19]
      validate_out <= (next_mode != mode) && (next_mode == mode_run); // [R16]
      clear_outputs_out <= (next_mode != mode) && (next_mode == mode_stop || next_mode == mode_debug); // [R17] [R19]
      input_refresh_out <= (next_mode != mode) && (next_mode == mode_debug); // [R19]
    end
  end

  // debug halt conditions; debug_go releases a halt and restarts scan counting
  assign halt_now = (debug_cond_in == dbg_step && instr_done_in) ||
                    (debug_cond_in == dbg_break && breakpoint_hit_in) ||
                    (debug_cond_in == dbg_device && device_cond_in) ||
                    (debug_cond_in == dbg_scans && scan_end_in && scan_count + 16'h0001 >= debug_scans_in); // [R20]
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      debug_halted_out <= 1'b0;
      scan_count <= 16'h0000;
    end else if (mode != mode_debug || debug_go_in) begin
      debug_halted_out <= 1'b0;
      scan_count <= 16'h0000;
    end else if (!debug_halted_out) begin
      debug_halted_out <= halt_now;
      scan_count <= scan_end_in ? scan_count + 16'h0001 : scan_count;
    end
  end

  // error record: ordinary errors warn, any error code lands in the one flag word
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      warning_out <= 1'b0;
      system_error_flag_out <= error_code_none;
    end else begin
      warning_out <= warning_out | ordinary; // [R12]
      if (fatal || ordinary) begin
        system_error_flag_out <= error_code_in; // [R15]
      end
    end
  end

  // run executes; stop, pause and a halted debug keep refreshing i/o only
  assign mode_out = mode;
  assign remote_out = remote;
  assign execute_out = running && (mode != mode_stop); // [R16] [R17] [R18]
  assign io_refresh_out = 1'b1; // [R17]

  chk_fatal_forces_stop: assert property (@(posedge clock_in) disable iff (reset_in)
    fatal |=> mode == mode_stop) else $error("fatal error did not stop"); // [R12]
  chk_debug_from_stop: assert property (@(posedge clock_in) disable iff (reset_in)
    (mode == mode_debug && $past(mode) != mode_debug) |-> $past(mode) == mode_stop) else $error("debug entered not from stop"); // [R19]
  chk_stop_clears_out: assert property (@(posedge clock_in) disable iff (reset_in)
    (mode == mode_stop && $past(mode) != mode_stop) |-> clear_outputs_out) else $error("stop entry without clear"); // [R17]
  chk_stop_no_exec: assert property (@(posedge clock_in) disable iff (reset_in)
    mode == mode_stop |-> !execute_out) else $error("program runs in stop"); // [R17]
  chk_pause_keeps_data: assert property (@(posedge clock_in) disable iff (reset_in)
    (mode == mode_run && $past(mode) == mode_pause) |-> !init_data_out) else $error("pause resume reinitialised"); // [R18]
  chk_preempt_order: assert property (@(posedge clock_in) disable iff (reset_in)
    preempt_out |=> current_id == $past(best_id) && stack_id == $past(current_id)) else $error("preemption wrong"); // [R4]
  chk_error_flag_code: assert property (@(posedge clock_in) disable iff (reset_in)
    (fatal || ordinary) |=> system_error_flag_out == $past(error_code_in)) else $error("error flag not written"); // [R15]
  chk_numeric_no_stop: assert property (@(posedge clock_in) disable iff (reset_in)
    (ordinary && !fatal && !stop_instruction_in && !switch_moved && !remote && mode == mode_run) |=>
    mode == mode_run && warning_out) else $error("ordinary error stopped cpu"); // [R14]
  chk_stop_instr: assert property (@(posedge clock_in) disable iff (reset_in)
    (stop_instruction_in && mode == mode_run) |=> mode == mode_stop) else $error("stop instruction ignored"); // [R21]
endmodule

// File: cpu_ctl_pkg.sv
// cpu_ctl_pkg: constants, modes and carrier structs for the cpu mode and interrupt control block
// assumes: shared by cpu_ctl_top, irq_source_unit, contact_model and the bench
package cpu_ctl_pkg;
  localparam int unsigned clock_period_ns = 100;
  localparam int unsigned period_unit_ms = 10;
  localparam int unsigned tick_cycles = (period_unit_ms * 1000000) / clock_period_ns;
  localparam int unsigned tick_width = 17;
  localparam int unsigned num_sources = 8;
  localparam int unsigned max_sources_std = 8;
  localparam int unsigned max_sources_eco = 4;
  localparam int unsigned num_counter_ch = 4;
  localparam int unsigned pend_width = 2;
  localparam logic [1:0] pend_limit = 2'h2;
  localparam logic [3:0] no_source = 4'hF;
  localparam logic [15:0] period_reset = 16'h0000;
  localparam logic [7:0] error_code_none = 8'h00;

  typedef enum logic [1:0] {
    src_periodic = 2'h0,
    src_edge = 2'h1,
    src_counter = 2'h2,
    src_unused = 2'h3
  } src_kind_type;

  typedef enum logic [1:0] {
    edge_rise = 2'h1,
    edge_fall = 2'h2,
    edge_both = 2'h3
  } edge_sel_type;

  // gray order along stop -> run -> pause, debug off stop
  typedef enum logic [1:0] {
    mode_stop = 2'h0,
    mode_run = 2'h1,
    mode_pause = 2'h3,
    mode_debug = 2'h2
  } mode_type;

  typedef enum logic [2:0] {
    sw_run = 3'h0,
    sw_stop = 3'h1,
    sw_stop_to_rem = 3'h2,
    sw_rem_to_run = 3'h3,
    sw_run_to_rem = 3'h4,
    sw_rem_to_stop = 3'h5
  } switch_pos_type;

  typedef enum logic [1:0] {
    dbg_step = 2'h0,
    dbg_break = 2'h1,
    dbg_device = 2'h2,
    dbg_scans = 2'h3
  } debug_cond_type;

  typedef struct packed {
    src_kind_type kind;
    edge_sel_type edge_sel;
    logic [1:0] channel;
    logic [2:0] priority_level;
    logic [15:0] period;
  } src_cfg_type;

  typedef struct packed {
    logic hw_fatal;
    logic config_mismatch;
    logic numeric_error;
    logic overrun;
    logic io_fail;
    logic ext_fatal;
    logic ext_ordinary;
  } error_in_type;
endpackage

// File: irq_source_unit.sv
// irq_source_unit: one interrupt source with trigger detect, enable gate and pending count
// assumes: clock_in at 10 MHz, tick_in one cycle every 10 ms, inputs synchronous to clock_in
`timescale 1ns/1ps
module irq_source_unit
  import cpu_ctl_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire src_cfg_type cfg_in,
  input wire logic economy_in,
  input wire logic tick_in,
  input wire logic contact_in,
  input wire logic [num_counter_ch-1:0] match_in,
  input wire logic enable_in,
  input wire logic take_in,
  input wire logic done_in,
  output logic pending_out,
  output logic active_out
);
  logic contact_prev;
  logic [15:0] period_count;
  logic [pend_width-1:0] pend_count;
  logic in_service;
  logic rise;
  logic fall;
  logic edge_hit;
  logic period_hit;
  logic trigger;
  logic accept;

  // economy parts ignore falling edges whatever the setting
  assign rise = contact_in & ~contact_prev;
  assign fall = ~contact_in & contact_prev & ~economy_in; // [R8]
  assign edge_hit = (cfg_in.edge_sel[0] & rise) | (cfg_in.edge_sel[1] & fall); // [R7]
  assign period_hit = tick_in && (period_count + 16'h0001 >= cfg_in.period) && (cfg_in.period != period_reset); // [R5]
  assign trigger = (cfg_in.kind == src_periodic) ? period_hit :
                   (cfg_in.kind == src_edge) ? edge_hit :
                   (cfg_in.kind == src_counter) ? match_in[cfg_in.channel] : 1'b0; // [R9]
  // triggers before enabling are dropped; beyond two queued the rest are dropped
  assign accept = trigger && enable_in && (pend_count < pend_limit); // [R1] [R11]
  assign pending_out = (pend_count != '0);
  assign active_out = in_service;

  // periodic count in 10 ms ticks, restarts each period
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      period_count <= period_reset;
      contact_prev <= 1'b0;
    end else begin
      contact_prev <= contact_in;
      if (period_hit) begin
        period_count <= period_reset;
      end else if (tick_in) begin
        period_count <= period_count + 16'h0001;
      end
    end
  end

  // pending count: accepted trigger adds, taken service removes
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pend_count <= '0;
      in_service <= 1'b0;
    end else begin
      pend_count <= pend_count + pend_width'(accept) - pend_width'(take_in);
      if (take_in) begin
        in_service <= 1'b1;
      end else if (done_in) begin
        in_service <= 1'b0;
      end
    end
  end

  chk_no_early_trigger: assert property (@(posedge clock_in) disable iff (reset_in)
    (!enable_in && !pending_out && !take_in) |=> !pending_out) else $error("trigger taken while disabled"); // [R1]
endmodule

// File: contact_model.sv
// contact_model: external input contacts and the front panel selector switch
// assumes: shares clock_in with the block; the bench calls its tasks to move contacts and switch
`timescale 1ns/1ps
module contact_model
  import cpu_ctl_pkg::*;
(
  input wire logic clock_in,
  output logic [num_sources-1:0] contact_out,
  output switch_pos_type switch_out
);
  // contacts open and the switch in stop, as after power up
  initial begin
    contact_out = 8'h00;
    switch_out = sw_stop;
  end
  // move just after an edge so the block sees one clean level per cycle
  task automatic set_contacts(input logic [num_sources-1:0] value);
    @(posedge clock_in);
    contact_out <= value;
  endtask
  // the switch sits in one position for at least a cycle, like a real detent
  task automatic set_switch(input switch_pos_type pos);
    @(posedge clock_in);
    switch_out <= pos;
  endtask
endmodule

// File: cpu_ctl_top_test.sv
// cpu_ctl_top_test: self-checking bench for mode changes, errors and interrupt service order
// assumes: cpu_ctl_pkg and contact_model compiled first; one 10 MHz clock
`timescale 1ns/1ps
module cpu_ctl_top_test;
  import cpu_ctl_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  src_cfg_type [num_sources-1:0] cfg;
  logic [num_sources-1:0] enable = 8'h00;
  logic [num_sources-1:0] contacts;
  logic [10:0] pulses = 11'h000;
  logic [3:0] fast_pulse_counter = 4'h0;
  logic [7:0] rp = 8'h03;
  logic eco = 1'b0;
  debug_cond_type dcond = dbg_step;
  error_in_type err = 7'h00;
  logic [7:0] code = 8'h00;
  logic [7:0] seed = 8'h5E;
  switch_pos_type sw;
  mode_type mode;
  logic remote, execute, init_data, clr_out, halted, cfg_err, warning, valid, in_ref, io_ref;
  logic [3:0] sid;
  logic [7:0] flag;
  int n_fail = 0;
  int checked = 0;
  mode_type mode_q[$];
  logic [3:0] id_q[$];
  // 10 MHz clock
  always #50 clock_in = ~clock_in;
  contact_model PART (.clock_in(clock_in), .contact_out(contacts), .switch_out(sw));
  cpu_ctl_top DUT (.clock_in(clock_in), .reset_in(reset_in), .economy_in(eco), .src_cfg_in(cfg),
    .routine_present_in(rp), .interrupt_enable_instruction_in(enable), .input_edge_interrupt_in(contacts),
    .counter_match_interrupt_in(fast_pulse_counter), .routine_return_in(pulses[0]), .error_in(err), .error_code_in(code),
    .switch_in(sw), .remote_run_req_in(pulses[6]), .remote_pause_req_in(pulses[7]),
    .remote_stop_req_in(pulses[3]), .remote_debug_req_in(pulses[2]), .stop_instruction_in(pulses[1]),
    .scan_end_in(pulses[10]), .debug_cond_in(dcond), .instr_done_in(pulses[4]), .breakpoint_hit_in(pulses[8]),
    .device_cond_in(pulses[9]), .debug_scans_in(16'h0002), .debug_go_in(pulses[5]), .mode_out(mode),
    .remote_out(remote), .execute_out(execute), .io_refresh_out(io_ref), .init_data_out(init_data),
    .clear_outputs_out(clr_out), .input_refresh_out(in_ref), .validate_out(valid), .debug_halted_out(halted),
    .service_id_out(sid), .preempt_out(), .config_error_out(cfg_err), .warning_out(warning),
    .system_error_flag_out(flag));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic compare_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // one-cycle strobe: 0 return, 1 stop instruction, 2 remote debug, 3 remote stop, 4 step done, 5 go,
  // 6 remote run, 7 remote pause, 8 breakpoint, 9 device condition, 10 scan end
  task automatic strobe(input int which);
    @(posedge clock_in);
    pulses <= 11'h001 << which;
    @(posedge clock_in);
    pulses <= 11'h000;
  endtask
  task automatic hit_error(input error_in_type e, input logic [7:0] c);
    @(posedge clock_in);
    err <= e;
    code <= c;
    @(posedge clock_in);
    err <= 7'h00;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watcher: every mode or service change takes the oldest note; an unnoted change can never match
  mode_type last_mode = mode_stop;
  logic [3:0] last_id = 4'hF;
  always @(posedge clock_in) begin
    logic [1:0] em;
    logic [3:0] ei;
    if (!reset_in && mode !== last_mode) begin
      em = (mode_q.size() > 0) ? mode_q.pop_front() : ~mode;
      compare_val({6'h00, mode}, {6'h00, em});
      compare_val({7'h00, init_data}, {7'h00, (mode == mode_run && last_mode != mode_pause) || mode == mode_debug});
      compare_val({7'h00, clr_out}, {7'h00, mode == mode_stop || mode == mode_debug});
      compare_val({7'h00, valid}, {7'h00, mode == mode_run});
      compare_val({7'h00, in_ref}, {7'h00, mode == mode_debug});
      compare_val({7'h00, io_ref}, 8'h01);
      last_mode = mode;
    end
    if (!reset_in && sid !== last_id) begin
      ei = (id_q.size() > 0) ? id_q.pop_front() : ~sid;
      compare_val({4'h0, sid}, {4'h0, ei});
      last_id = sid;
    end
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    tick(20000);
    n_fail++;
    print_verdict();
  end
  // main sequence
  initial begin
    for (int i = 0; i < num_sources; i++) cfg[i] = '{src_unused, edge_rise, 2'h0, 3'h7, period_reset};
    cfg[0] = '{src_edge, edge_rise, 2'h0, 3'h1, period_reset};
    cfg[1] = '{src_edge, edge_fall, 2'h0, 3'h0, period_reset};
    tick(8);
    reset_in <= 1'b0;
    tick(2);
    compare_val({6'h00, mode}, {6'h00, mode_stop});
    compare_val({4'h0, sid}, 8'h0F);
    compare_val(flag, error_code_none);
    cfg[2].kind <= src_edge;
    tick(2);
    compare_val({7'h00, cfg_err}, 8'h01);
    cfg[2].kind <= src_unused;
    tick(2);
    compare_val({7'h00, cfg_err}, 8'h00);
    mode_q.push_back(mode_run);
    PART.set_switch(sw_run);
    tick(3);
    compare_val({7'h00, execute}, 8'h01);
    $display("test reset and run entry done");
    // edges seen while disabled are dropped; a fall on a rise-only contact does nothing
    PART.set_contacts(8'h03);
    tick(3);
    enable <= 8'h03;
    tick(6);
    PART.set_contacts(8'h02);
    tick(6);
    compare_val({4'h0, sid}, 8'h0F);
    // contact 0 rises and contact 1 falls together: level 0 source goes first
    // a return with no stacked routine shows idle for one cycle before the waiting source is taken
    id_q = '{4'h1, 4'hF, 4'h0, 4'hF};
    PART.set_contacts(8'h01);
    tick(6);
    strobe(0);
    tick(4);
    strobe(0);
    tick(4);
    compare_val(8'(id_q.size()), 8'h00);
    // contact 1 falls while source 0 runs and must preempt it
    PART.set_contacts(8'h00);
    tick(3);
    id_q = '{4'h0};
    PART.set_contacts(8'h01);
    tick(6);
    PART.set_contacts(8'h03);
    tick(3);
    id_q = '{4'h1, 4'h0, 4'hF};
    PART.set_contacts(8'h01);
    tick(6);
    strobe(0);
    tick(4);
    strobe(0);
    tick(4);
    compare_val(8'(id_q.size()), 8'h00);
    // counter match on channel 1 drives source 2; routine and config change together
    cfg[2] <= '{src_counter, edge_rise, 2'h1, 3'h2, period_reset};
    rp <= 8'h07;
    enable <= 8'h07;
    id_q = '{4'h2, 4'hF};
    tick(2);
    fast_pulse_counter <= 4'h2;
    tick(1);
    fast_pulse_counter <= 4'h0;
    tick(4);
    strobe(0);
    tick(3);
    compare_val(8'(id_q.size()), 8'h00);
    // economy parts never fire on a falling contact
    eco <= 1'b1;
    PART.set_contacts(8'h03);
    tick(3);
    PART.set_contacts(8'h01);
    tick(6);
    compare_val({4'h0, sid}, 8'h0F);
    eco <= 1'b0;
    $display("test interrupts done");
    // every error kind; fatal ones stop and the switch restarts the program
    for (int i = 0; i < 7; i++) begin
      seed = lfsr_next(seed);
      if (i != 0 && i != 4) mode_q.push_back(mode_stop);
      hit_error(error_in_type'(7'h01 << i), seed);
      tick(3);
      compare_val(flag, seed);
      if (i != 0 && i != 4) begin
        PART.set_switch(sw_stop);
        mode_q.push_back(mode_run);
        PART.set_switch(sw_run);
        tick(3);
      end
    end
    compare_val({7'h00, warning}, 8'h01);
    mode_q.push_back(mode_stop);
    strobe(1);
    tick(3);
    $display("test errors and stop instruction done");
    // remote stop, debug entry and halt, then the remaining switch moves
    PART.set_switch(sw_stop);
    PART.set_switch(sw_stop_to_rem);
    tick(2);
    compare_val({7'h00, remote}, 8'h01);
    mode_q.push_back(mode_debug);
    strobe(2);
    tick(3);
    strobe(4);
    tick(3);
    compare_val({7'h00, halted}, 8'h01);
    strobe(5);
    tick(3);
    compare_val({7'h00, halted}, 8'h00);
    // breakpoint, device condition and a count of two scans each halt, go releases
    for (int c = 1; c < 4; c++) begin
      dcond <= debug_cond_type'(c);
      strobe(c + 7);
      strobe(c + 7);
      tick(3);
      compare_val({7'h00, halted}, 8'h01);
      strobe(5);
      tick(2);
    end
    // remote tool walks stop, run, pause and back before the switch takes over
    mode_q = '{mode_stop, mode_run, mode_pause, mode_run, mode_stop,
               mode_run, mode_pause, mode_run, mode_pause, mode_stop};
    strobe(3);
    strobe(6);
    strobe(7);
    strobe(6);
    strobe(3);
    tick(3);
    PART.set_switch(sw_rem_to_run);
    tick(3);
    compare_val({7'h00, remote}, 8'h00);
    PART.set_switch(sw_run_to_rem);
    tick(3);
    PART.set_switch(sw_rem_to_run);
    tick(3);
    PART.set_switch(sw_run_to_rem);
    tick(3);
    PART.set_switch(sw_rem_to_stop);
    tick(3);
    compare_val(8'(mode_q.size()), 8'h00);
    $display("test debug and switch done");
    print_verdict();
  end
endmodule
